// ===== logic/dsl_top.sv
// Contract
// - Twenty-four bit shift register takes one serial bit per falling link clock.
// - Readback bits leave on serial output, changing on rising link clock edges.
// - Low frame select opens a frame and enables shifting on falling edges.
// - Rising frame select applies the held word to its addressed register if exactly 24 bits were shifted.
// - Load strobe low: DAC register and output follow a write at frame end.
// - Load strobe high: only input register written; DAC waits for strobe fall.
// - Reset low returns every register except the buffer storage, and the output, to power-on state.
// - Clear low loads DAC register with programmed clear value, output follows.
// - Clear value interpreted per selected coding, binary or twos complement.
// - Serial output released to high impedance after frame select rises.
`timescale 1ns/1ps
`default_nettype none
module dsl_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic load_output_n,
  input wire logic clear_to_value_n,
  output logic [dsl_pkg::DSL_CODE_W-1:0] dac_level,
  output logic twos_comp,
  output logic link_busy
);
  import dsl_pkg::*;

  // ==========================================================================
  // Link domain: capture
  // ==========================================================================
  logic link_idle;
  logic [DSL_WORD_W-1:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic in_armed_reg;
  logic [DSL_WORD_W-1:0] out_shift_reg;
  logic out_armed_reg;
  logic oe_reg;
  logic sout_reg;
  logic [DSL_WORD_W-1:0] rb_word_reg;

  // Idle between frames or in reset; used as async arm for frame start
  assign link_idle = frame_n | ~rst_n;

  // Shift only while the frame is open
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (!frame_n) begin
      shift_reg <= {shift_reg[DSL_WORD_W-2:0], serial_in};
    end
  end

  // Arm flag set between frames so the first edge restarts the count
  always_ff @(negedge sclk or posedge link_idle) begin
    if (link_idle) begin
      in_armed_reg <= 1'b1;
    end else begin
      in_armed_reg <= 1'b0;
    end
  end

  // Count kept after the frame so the system side can judge the word length
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
    end else if (!frame_n) begin
      if (in_armed_reg) begin
        bit_cnt_reg <= 5'h01;
      end else if (bit_cnt_reg != DSL_CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // ==========================================================================
  // Link domain: readback
  // ==========================================================================
  always_ff @(posedge sclk or posedge link_idle) begin
    if (link_idle) begin
      out_armed_reg <= 1'b1;
    end else begin
      out_armed_reg <= 1'b0;
    end
  end

  // Readback word is quasi-static: it only changes after a frame has ended
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift_reg <= '0;
      sout_reg <= 1'b0;
    end else if (!frame_n) begin
      if (out_armed_reg) begin
        sout_reg <= rb_word_reg[DSL_WORD_W-1];
        out_shift_reg <= {rb_word_reg[DSL_WORD_W-2:0], 1'b0};
      end else begin
        sout_reg <= out_shift_reg[DSL_WORD_W-1];
        out_shift_reg <= {out_shift_reg[DSL_WORD_W-2:0], 1'b0};
      end
    end
  end

  // Driver released the moment the frame closes, no clock edge needed
  always_ff @(posedge sclk or posedge link_idle) begin
    if (link_idle) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= 1'b1;
    end
  end

  assign serial_out = sout_reg;
  assign serial_out_oe = oe_reg;

  // ==========================================================================
  // System domain: pin synchronisers
  // ==========================================================================
  // Bits: 2 frame, 1 load strobe, 0 clear
  logic [2:0] sync_s1_reg;
  logic [2:0] sync_s2_reg;
  logic frame_d_reg;
  logic load_output_n_d_reg;
  logic frame_s;
  logic load_output_n_s;
  logic clr_s;
  logic frame_rise;
  logic load_output_n_fall;

  // Strobes sampled on the free-running clock, independent of the link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1_reg <= DSL_SYNC_RST;
      sync_s2_reg <= DSL_SYNC_RST;
    end else begin
      sync_s1_reg <= {frame_n, load_output_n, clear_to_value_n};
      sync_s2_reg <= sync_s1_reg;
    end
  end

  assign frame_s = sync_s2_reg[2];
  assign load_output_n_s = sync_s2_reg[1];
  assign clr_s = sync_s2_reg[0];

  // Edge history taken from the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_d_reg <= 1'b1;
      load_output_n_d_reg <= 1'b1;
    end else begin
      frame_d_reg <= frame_s;
      load_output_n_d_reg <= load_output_n_s;
    end
  end

  assign frame_rise = frame_s & ~frame_d_reg;
  assign load_output_n_fall = ~load_output_n_s & load_output_n_d_reg;

  // ==========================================================================
  // System domain: word buffer
  // ==========================================================================
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  dsl_word_t pop_word;
  logic [DSL_WORD_W-1:0] pop_bits;

  // Short frames are dropped; the word is stable since shifting stopped
  assign push_valid = frame_rise & (bit_cnt_reg == DSL_CNT_FULL);
  // Words wait while clear is held so clear keeps priority
  assign pop_ready = clr_s;

  dsl_buf #(
    .WIDTH(DSL_WORD_W),
    .DEPTH(DSL_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(shift_reg),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_bits)
  );

  assign pop_word = dsl_word_t'(pop_bits);

  // Full buffer shown to the host so it spaces its frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_busy <= 1'b0;
    end else begin
      link_busy <= ~push_ready;
    end
  end

  // ==========================================================================
  // System domain: registers
  // ==========================================================================
  logic apply;
  logic wr_dac;
  logic [DSL_CODE_W-1:0] input_code_reg;
  logic [DSL_CODE_W-1:0] dac_code_reg;
  logic [DSL_CODE_W-1:0] dac_next;
  logic [DSL_CODE_W-1:0] clear_code_reg;
  logic twos_reg;
  logic twos_next;

  assign apply = pop_valid & pop_ready;
  assign wr_dac = apply & ~pop_word.rd & (pop_word.addr == DSL_ADDR_DAC);

  // Input register, clear code and coding select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_code_reg <= DSL_DAC_RST;
      clear_code_reg <= DSL_CLR_RST;
      twos_reg <= DSL_TWOS_RST;
    end else if (apply && !pop_word.rd) begin
      if (pop_word.addr == DSL_ADDR_DAC) begin
        input_code_reg <= pop_word.data[DSL_CODE_W-1:0];
      end
      if (pop_word.addr == DSL_ADDR_CLR) begin
        clear_code_reg <= pop_word.data[DSL_CODE_W-1:0];
      end
      if (pop_word.addr == DSL_ADDR_CTRL) begin
        twos_reg <= pop_word.data[DSL_CTRL_TWOS_BIT];
      end
    end
  end

  assign twos_next = twos_reg;

  // DAC register: clear beats load strobe beats a fresh write
  always_comb begin
    dac_next = dac_code_reg;
    if (!clr_s) begin
      dac_next = clear_code_reg;
    end else if (load_output_n_fall) begin
      dac_next = input_code_reg;
    end else if (wr_dac && !load_output_n_s) begin
      dac_next = pop_word.data[DSL_CODE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_reg <= DSL_DAC_RST;
    end else begin
      dac_code_reg <= dac_next;
    end
  end

  // Analog stage wants offset binary, so twos complement flips the top bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_level <= DSL_DAC_RST;
      twos_comp <= DSL_TWOS_RST;
    end else begin
      dac_level <= twos_next ? {~dac_next[DSL_CODE_W-1], dac_next[DSL_CODE_W-2:0]}
                             : dac_next;
      twos_comp <= twos_next;
    end
  end

  // Readback word answered in the following frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_word_reg <= DSL_RB_RST;
    end else if (apply && pop_word.rd) begin
      case (pop_word.addr)
        DSL_ADDR_DAC: rb_word_reg <= {pop_word.rd, pop_word.addr, 2'b00, dac_code_reg};
        DSL_ADDR_CLR: rb_word_reg <= {pop_word.rd, pop_word.addr, 2'b00, clear_code_reg};
        DSL_ADDR_CTRL: rb_word_reg <= {pop_word.rd, pop_word.addr, 18'h00000, twos_reg, 1'b0};
        default: rb_word_reg <= {pop_word.rd, pop_word.addr, 20'h00000};
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence clr_fall_s;
    $fell(clr_s);
  endsequence

  sequence load_output_n_fall_s;
    clr_s && load_output_n_fall;
  endsequence

  chk_shift_capture: assert property (@(negedge sclk) disable iff (!rst_n)
    !frame_n |=> shift_reg[0] == $past(serial_in))
    else $error("serial bit not captured on falling edge");

  chk_frame_gate: assert property (@(negedge sclk) disable iff (!rst_n)
    frame_n |=> $stable(shift_reg))
    else $error("shift register moved outside a frame");

  chk_readback_first: assert property (@(posedge sclk) disable iff (!rst_n)
    (!frame_n && out_armed_reg) |=> serial_out == $past(rb_word_reg[DSL_WORD_W-1]))
    else $error("readback first bit wrong");

  chk_push_word: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_rise && bit_cnt_reg == DSL_CNT_FULL && push_ready) |=> pop_valid)
    else $error("complete frame not queued");

  chk_oe_release: assert property (@(posedge clk) disable iff (!rst_n)
    frame_n |-> !serial_out_oe)
    else $error("serial output still driven after frame");

  chk_clear_load: assert property (@(posedge clk) disable iff (!rst_n)
    clr_fall_s |=> dac_code_reg == $past(clear_code_reg))
    else $error("clear did not load clear code");

  chk_load_output_n_load: assert property (@(posedge clk) disable iff (!rst_n)
    load_output_n_fall_s |=> dac_code_reg == $past(input_code_reg))
    else $error("load strobe fall did not update DAC");

  chk_load_output_n_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_dac && load_output_n_s && clr_s && !load_output_n_fall) |=> $stable(dac_code_reg))
    else $error("DAC updated while load strobe high");

  chk_tied_low: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_dac && !load_output_n_s && clr_s && !load_output_n_fall)
      |=> dac_code_reg == $past(pop_word.data[DSL_CODE_W-1:0]))
    else $error("write with strobe low did not reach DAC");

  chk_coding: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> dac_level == (twos_comp ? {~dac_code_reg[DSL_CODE_W-1],
      dac_code_reg[DSL_CODE_W-2:0]} : dac_code_reg))
    else $error("output level ignores coding");

  chk_reset_state: assert property (@(posedge clk)
    !rst_n |-> (dac_code_reg == DSL_DAC_RST && dac_level == DSL_DAC_RST && !link_busy))
    else $error("reset state not restored");

endmodule : dsl_top
`default_nettype wire

// ===== logic/dsl_pkg.sv
package dsl_pkg;

  // ==========================================================================
  // Serial word layout
  // ==========================================================================
  localparam int DSL_WORD_W = 24;
  localparam int DSL_ADDR_W = 3;
  localparam int DSL_DATA_W = 20;
  localparam int DSL_CODE_W = 18;
  localparam int DSL_CTRL_TWOS_BIT = 1;

  // Command word: read flag, target address, payload
  typedef struct packed {
    logic rd;
    logic [DSL_ADDR_W-1:0] addr;
    logic [DSL_DATA_W-1:0] data;
  } dsl_word_t;

  // ==========================================================================
  // Internal register addresses
  // ==========================================================================
  localparam logic [DSL_ADDR_W-1:0] DSL_ADDR_DAC = 3'h1;
  localparam logic [DSL_ADDR_W-1:0] DSL_ADDR_CTRL = 3'h2;
  localparam logic [DSL_ADDR_W-1:0] DSL_ADDR_CLR = 3'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DSL_CODE_W-1:0] DSL_DAC_RST = 18'h00000;
  localparam logic [DSL_CODE_W-1:0] DSL_CLR_RST = 18'h00000;
  localparam logic DSL_TWOS_RST = 1'b0;
  localparam logic [DSL_WORD_W-1:0] DSL_RB_RST = 24'h000000;
  localparam logic [2:0] DSL_SYNC_RST = 3'h7;

  // ==========================================================================
  // Frame bit counting and buffering
  // ==========================================================================
  localparam logic [4:0] DSL_CNT_FULL = 5'h18;
  localparam logic [4:0] DSL_CNT_MAX = 5'h1F;
  localparam int DSL_BUF_DEPTH = 2;

  // ==========================================================================
  // Link clock limits kept by the host
  // ==========================================================================
  localparam int DSL_SCLK_WR_MAX_MHZ = 35;
  localparam int DSL_SCLK_RD_MAX_MHZ = 16;

endpackage : dsl_pkg

// ===== logic/dsl_buf.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  // ==========================================================================
  // Handshake
  // ==========================================================================
  assign in_ready = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage, no reset needed since count guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth, not at a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : dsl_buf
`default_nettype wire

// ===== dv/dsl_host.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host side serial master model
module dsl_host (
  output logic sclk,
  output logic frame_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [23:0] rx;
  // Idle: link clock parked low, frame closed
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    serial_in = 1'b0;
    rx = 24'h000000;
  end
  // One frame, MSB first; half period sets the link rate
  task automatic xfer(input logic [23:0] w, input int nbits, input int half,
                      output logic [23:0] rd);
    #7;
    frame_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      #(half);
      sclk = 1'b1;
      serial_in = w[23-i];
      #(half);
      sclk = 1'b0;
      // A released output line reads unknown, so oe slips fail the compare
      rx = {rx[22:0], serial_out_oe ? serial_out : 1'bx};
    end
    #(half);
    frame_n = 1'b1;
    serial_in = ~serial_in; // No stale level once the frame is over
    // Stray clock pair with the frame closed must leave the shift register alone
    #(half);
    sclk = 1'b1;
    #(half);
    sclk = 1'b0;
    rd = rx;
  endtask : xfer
endmodule : dsl_host
`default_nettype wire

// ===== dv/dsl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
// ============================================================
// Bench top
module dsl_top_tb;
  import dsl_pkg::*;
  logic clk, rst_n, load_output_n, clear_to_value_n, twos_comp, link_busy;
  wire logic sclk, frame_n, serial_in, serial_out, serial_out_oe;
  logic [DSL_CODE_W-1:0] dac_level;
  logic [23:0] rb;
  int n_errors = 0, tests_run = 0, c, seed, exp_in, exp_dac, exp_clr;
  bit exp_twos, last_rd;
  logic [23:0] pend[$];

  dsl_top u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .frame_n(frame_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .load_output_n(load_output_n), .clear_to_value_n(clear_to_value_n),
    .dac_level(dac_level), .twos_comp(twos_comp), .link_busy(link_busy));
  dsl_host u_host (.sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  // 100 MHz system clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ============================================================
  // Reference model
  function automatic logic [17:0] lvl(input int code);
    return exp_twos ? (code[17:0] ^ 18'h20000) : code[17:0];
  endfunction : lvl

  // Queued words apply only while clear is released
  task automatic apply();
    logic [23:0] w;
    while (pend.size() > 0) begin
      w = pend.pop_front();
      if (w[22:20] == DSL_ADDR_DAC) exp_in = w[17:0];
      if (w[22:20] == DSL_ADDR_DAC && !load_output_n) exp_dac = w[17:0];
      if (w[22:20] == DSL_ADDR_CTRL) exp_twos = w[DSL_CTRL_TWOS_BIT];
      if (w[22:20] == DSL_ADDR_CLR) exp_clr = w[17:0];
    end
  endtask : apply

  // Readback frames and the one after them run at the slow rate
  task automatic frame(input logic [23:0] w, input int nb, output logic [23:0] rd);
    u_host.xfer(w, nb, (w[23] || last_rd) ? 32 : 16, rd);
    last_rd = w[23];
    if (nb == 24 && !w[23] && pend.size() < 2) pend.push_back(w);
    repeat (10) @(negedge clk);
    if (clear_to_value_n) apply();
  endtask : frame

  task automatic wr(input logic [2:0] a, input int d, input int nb);
    frame({1'b0, a, 2'h0, d[17:0]}, nb, rb);
  endtask : wr

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  initial begin
    #500000;
    n_errors++;
    give_verdict();
  end

  // ============================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    load_output_n = 1'b0;
    clear_to_value_n = 1'b1;
    {exp_in, exp_dac, exp_clr, exp_twos, last_rd} = '0;
    seed = $urandom(32'h71BE);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    // Write with load strobe low updates the output at frame end
    c = $urandom;
    wr(DSL_ADDR_DAC, c, 24);
    `CHK(dac_level, lvl(exp_dac))
    // Short frame must be ignored
    wr(DSL_ADDR_DAC, ~c, 23);
    `CHK(dac_level, lvl(exp_dac))
    done("write");
    // Twos complement coding
    wr(DSL_ADDR_CTRL, 32'h2, 24);
    `CHK(twos_comp, 1'b1)
    c = $urandom;
    wr(DSL_ADDR_DAC, c, 24);
    `CHK(dac_level, lvl(exp_dac))
    done("coding");
    // Held-off update, then strobe fall with the link clock idle
    load_output_n = 1'b1;
    wr(DSL_ADDR_DAC, $urandom, 24);
    `CHK(dac_level, lvl(exp_dac))
    load_output_n = 1'b0;
    exp_dac = exp_in;
    repeat (6) @(negedge clk);
    `CHK(dac_level, lvl(exp_dac))
    done("strobe");
    // Clear to programmed value under twos complement
    wr(DSL_ADDR_CLR, $urandom, 24);
    `CHK(dac_level, lvl(exp_dac))
    clear_to_value_n = 1'b0;
    exp_dac = exp_clr;
    repeat (6) @(negedge clk);
    `CHK(dac_level, lvl(exp_dac))
    done("clear");
    // Buffer fills while clear holds words back; third word is dropped
    for (int i = 0; i < 2; i++) wr(DSL_ADDR_DAC, $urandom, 24);
    `CHK(link_busy, 1'b1)
    wr(DSL_ADDR_DAC, $urandom, 24);
    `CHK(dac_level, lvl(exp_dac))
    clear_to_value_n = 1'b1;
    apply();
    repeat (10) @(negedge clk);
    `CHK(dac_level, lvl(exp_dac))
    `CHK(link_busy, 1'b0)
    done("buffer");
    // Readback chain: each frame returns the word selected before it
    frame({1'b1, DSL_ADDR_DAC, 20'h00000}, 24, rb);
    frame({1'b1, DSL_ADDR_CLR, 20'h00000}, 24, rb);
    `CHK(rb, {1'b1, DSL_ADDR_DAC, 2'h0, exp_dac[17:0]})
    `CHK(serial_out_oe, 1'b0)
    frame({1'b1, DSL_ADDR_CTRL, 20'h00000}, 24, rb);
    `CHK(rb, {1'b1, DSL_ADDR_CLR, 2'h0, exp_clr[17:0]})
    `CHK(serial_out_oe, 1'b0)
    frame(24'h000000, 24, rb);
    `CHK(rb, {1'b1, DSL_ADDR_CTRL, 18'h00000, exp_twos, 1'b0})
    done("readback");
    // Reset in mid-run
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(dac_level, DSL_DAC_RST)
    `CHK(twos_comp, DSL_TWOS_RST)
    `CHK(link_busy, 1'b0)
    `CHK(serial_out_oe, 1'b0)
    {exp_in, exp_dac, exp_clr, exp_twos} = '0;
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    wr(DSL_ADDR_DAC, $urandom, 24);
    `CHK(dac_level, lvl(exp_dac))
    done("reset");
    give_verdict();
  end
endmodule : dsl_top_tb
`default_nettype wire
